// File: rtl/ltc_pkg.sv
package ltc_pkg;
   // system clock
   localparam int unsigned CLOCK_PERIOD_NS = 5;
   // crystal edges per prescaled tick
   localparam int unsigned XTAL_PER_FAST_TICK = 32;
   localparam int unsigned XTAL_PER_SLOW_TICK = 32768;
   // system cycles from readback request to readable count
   localparam logic [3:0]  READBACK_CYCLES    = 4'h8;
   // prescaled ticks of suppressed flags after a count, compare or period load
   localparam logic [1:0]  MUTE_TICKS         = 2'h2;
   // register indices, byte address is four times the index
   localparam logic [5:0]  IDX_CTRL           = 6'h00;
   localparam logic [5:0]  IDX_SYNC           = 6'h01;
   localparam logic [5:0]  IDX_INTLVL         = 6'h02;
   localparam logic [5:0]  IDX_FLAGS          = 6'h03;
   localparam logic [5:0]  IDX_CNT0           = 6'h04;
   localparam logic [5:0]  IDX_CNT3           = 6'h07;
   localparam logic [5:0]  IDX_PER0           = 6'h08;
   localparam logic [5:0]  IDX_PER3           = 6'h0B;
   localparam logic [5:0]  IDX_CMP0           = 6'h0C;
   localparam logic [5:0]  IDX_CMP3           = 6'h0F;
   localparam logic [5:0]  IDX_IRQ_STAT       = 6'h10;
   localparam logic [5:0]  IDX_IRQ_CLR        = 6'h11;
   localparam logic [5:0]  IDX_IRQ_EN         = 6'h12;
   // field positions
   localparam int unsigned CTRL_EN_BIT        = 0;
   localparam int unsigned SYNC_BUSY_BIT      = 0;
   localparam int unsigned SYNC_CNT_BIT       = 4;
   localparam int unsigned LVL_WRAP_LSB       = 0;
   localparam int unsigned LVL_MATCH_LSB      = 2;
   localparam int unsigned FLAG_WRAP          = 0;
   localparam int unsigned FLAG_MATCH         = 1;
   // reset values
   localparam logic [31:0] WORD_RESET         = 32'h0000_0000;
   localparam logic [7:0]  BYTE_RESET         = 8'h00;
   // bus responses
   localparam logic [1:0]  RESP_OKAY          = 2'h0;
   localparam logic [1:0]  RESP_DECERR        = 2'h3;
endpackage

// File: rtl/ltc_sync2.sv
module ltc_sync2 (
   input  wire logic clock,
   input  wire logic srst,
   input  wire logic d,
   output logic      q
);
   logic meta_q;

   // first stage feeds only the second
   always_ff @(posedge clock) begin
      if (srst) begin
         meta_q <= 1'b0;
         q      <= 1'b0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

// File: rtl/ltc_prescaler.sv
module ltc_prescaler #(
   parameter int unsigned SLOW_XTAL = ltc_pkg::XTAL_PER_SLOW_TICK
) (
   input  wire logic clock,
   input  wire logic srst,
   input  wire logic xtal_level,
   input  wire logic sel_1hz,
   output logic      rise_tick,
   output logic      half_tick
);
   localparam logic [15:0] HALF_FAST =
      16'(ltc_pkg::XTAL_PER_FAST_TICK / 2 - 1);
   localparam logic [15:0] HALF_SLOW = 16'(SLOW_XTAL / 2 - 1);

   logic        xtal_prev_q;
   logic        slow_lvl_q;
   logic [15:0] div_q;
   logic        xtal_rise;
   logic [15:0] half_end;

   assign xtal_rise = xtal_level & ~xtal_prev_q;
   assign half_end  = sel_1hz ? HALF_SLOW : HALF_FAST;

   // divides crystal edges into the 1.024 kHz or 1 Hz tick
   always_ff @(posedge clock) begin
      if (srst) begin
         xtal_prev_q <= 1'b0;
         slow_lvl_q  <= 1'b0;
         div_q       <= 16'h0000;
         rise_tick   <= 1'b0;
         half_tick   <= 1'b0;
      end else begin
         xtal_prev_q <= xtal_level;
         rise_tick   <= 1'b0;
         half_tick   <= 1'b0;
         if (xtal_rise) begin
            if (div_q >= half_end) begin
               div_q      <= 16'h0000;
               slow_lvl_q <= ~slow_lvl_q;
               half_tick  <= 1'b1;
               rise_tick  <= ~slow_lvl_q;
            end else begin
               div_q <= div_q + 16'h0001;
            end
         end
      end
   end
endmodule

// File: rtl/ltc_long_time_counter.sv
// The AXI4-Lite slave port was left to the implementer.
module ltc_long_time_counter #(
   parameter int unsigned SLOW_XTAL = ltc_pkg::XTAL_PER_SLOW_TICK
) (
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic        xtal_in,
   input  wire logic        sel_1hz,
   input  wire logic        match_irq_ack,
   input  wire logic        wrap_irq_ack,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   output logic             irq,
   output logic             match_irq_req,
   output logic [1:0]       match_irq_priority,
   output logic             wrap_irq_req,
   output logic [1:0]       wrap_irq_priority,
   output logic             match_event,
   output logic             wrap_event,
   output logic             wake_request
);
   logic        xtal_sync;
   logic        rise_tick;
   logic        half_tick;
   logic        aw_got_q;
   logic        w_got_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        enable_q;
   logic        enable_live_q;
   logic        ctrl_pend_q;
   logic        cnt_pend_q;
   logic [31:0] cnt_stage_q;
   logic [31:0] count_q;
   logic [31:0] period_q;
   logic [31:0] compare_q;
   logic [31:0] readback_q;
   logic        rb_req_q;
   logic [3:0]  rb_cnt_q;
   logic [1:0]  match_lvl_q;
   logic [1:0]  wrap_lvl_q;
   logic [1:0]  irq_en_q;
   logic [1:0]  flag_q;
   logic [1:0]  arm_q;
   logic [1:0]  mute_q;
   logic [1:0]  set_v;
   logic [1:0]  clr_v;
   logic [1:0]  event_q;
   logic        wr_fire;
   logic [5:0]  wr_idx;
   logic        wr_ok;
   logic [7:0]  wr_byte;
   logic        busy;
   logic        run;
   logic        wrap_hit;
   logic        match_hit;
   logic        wr_cnt;
   logic        wr_per;
   logic        wr_rb;
   logic [31:0] rd_word;
   logic        rd_mapped;
   logic        wr_mapped;

   ltc_sync2 u_sync (
      .clock (clock),
      .srst  (srst),
      .d     (xtal_in),
      .q     (xtal_sync)
   );

   ltc_prescaler #(
      .SLOW_XTAL (SLOW_XTAL)
   ) u_presc (
      .clock      (clock),
      .srst       (srst),
      .xtal_level (xtal_sync),
      .sel_1hz    (sel_1hz),
      .rise_tick  (rise_tick),
      .half_tick  (half_tick)
   );

   function automatic logic is_mapped(input logic [5:0] idx);
      is_mapped = idx <= ltc_pkg::IDX_IRQ_EN;
   endfunction

   // write channel: address and data in either order
   assign wr_fire   = aw_got_q & w_got_q & ~bvalid;
   assign wr_idx    = awaddr_q[7:2];
   assign wr_mapped = is_mapped(wr_idx);
   assign wr_ok     = wr_fire & wr_mapped & wstrb_q[0];
   assign wr_byte   = wdata_q[7:0];
   assign busy      = ctrl_pend_q | cnt_pend_q;
   assign wr_cnt    = wr_ok & (wr_idx >= ltc_pkg::IDX_CNT0)
                      & (wr_idx <= ltc_pkg::IDX_CNT3);
   assign wr_per    = wr_ok & (wr_idx >= ltc_pkg::IDX_PER0)
                      & (wr_idx <= ltc_pkg::IDX_PER3);
   assign wr_rb     = wr_ok & (wr_idx == ltc_pkg::IDX_SYNC)
                      & wr_byte[ltc_pkg::SYNC_CNT_BIT];

   always_ff @(posedge clock) begin
      if (srst) begin
         awready  <= 1'b0;
         wready   <= 1'b0;
         aw_got_q <= 1'b0;
         w_got_q  <= 1'b0;
         awaddr_q <= ltc_pkg::BYTE_RESET;
         wdata_q  <= ltc_pkg::WORD_RESET;
         wstrb_q  <= 4'h0;
         bvalid   <= 1'b0;
         bresp    <= ltc_pkg::RESP_OKAY;
      end else begin
         if (awvalid & awready) begin
            awready  <= 1'b0;
            aw_got_q <= 1'b1;
            awaddr_q <= awaddr;
         end else if (~aw_got_q & ~bvalid) begin
            awready <= 1'b1;
         end
         if (wvalid & wready) begin
            wready  <= 1'b0;
            w_got_q <= 1'b1;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end else if (~w_got_q & ~bvalid) begin
            wready <= 1'b1;
         end
         if (wr_fire) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            bvalid   <= 1'b1;
            bresp    <= wr_mapped ? ltc_pkg::RESP_OKAY
                                  : ltc_pkg::RESP_DECERR;
         end else if (bvalid & bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // control and priority registers, reserved bits dropped
   always_ff @(posedge clock) begin
      if (srst) begin
         enable_q    <= 1'b0;
         match_lvl_q <= 2'h0;
         wrap_lvl_q  <= 2'h0;
         irq_en_q    <= 2'h0;
      end else if (wr_ok) begin
         if (wr_idx == ltc_pkg::IDX_CTRL) begin
            enable_q <= wr_byte[ltc_pkg::CTRL_EN_BIT];
         end
         if (wr_idx == ltc_pkg::IDX_INTLVL) begin
            match_lvl_q <= wr_byte[ltc_pkg::LVL_MATCH_LSB +: 2];
            wrap_lvl_q  <= wr_byte[ltc_pkg::LVL_WRAP_LSB +: 2];
         end
         if (wr_idx == ltc_pkg::IDX_IRQ_EN) begin
            irq_en_q <= wr_byte[1:0];
         end
      end
   end

   // transfers into the tick side, acknowledged on a half tick
   always_ff @(posedge clock) begin
      if (srst) begin
         ctrl_pend_q   <= 1'b0;
         cnt_pend_q    <= 1'b0;
         enable_live_q <= 1'b0;
         cnt_stage_q   <= ltc_pkg::WORD_RESET;
      end else begin
         if (half_tick & ctrl_pend_q) begin
            enable_live_q <= enable_q;
         end
         if (wr_ok & (wr_idx == ltc_pkg::IDX_CTRL)) begin
            ctrl_pend_q <= 1'b1;
         end else if (half_tick) begin
            ctrl_pend_q <= 1'b0;
         end
         if (wr_cnt & ~busy) begin
            cnt_stage_q[8*(wr_idx[1:0]) +: 8] <= wr_byte;
         end
         if (wr_cnt & ~busy & (wr_idx == ltc_pkg::IDX_CNT3)) begin
            cnt_pend_q <= 1'b1;
         end else if (half_tick) begin
            cnt_pend_q <= 1'b0;
         end
      end
   end

   // period and compare values
   always_ff @(posedge clock) begin
      if (srst) begin
         period_q  <= ltc_pkg::WORD_RESET;
         compare_q <= ltc_pkg::WORD_RESET;
      end else begin
         if (wr_per & ~enable_q & ~busy) begin
            period_q[8*(wr_idx[1:0]) +: 8] <= wr_byte;
         end
         if (wr_ok & (wr_idx >= ltc_pkg::IDX_CMP0)
             & (wr_idx <= ltc_pkg::IDX_CMP3)) begin
            compare_q[8*(wr_idx[1:0]) +: 8] <= wr_byte;
         end
      end
   end

   assign run       = enable_live_q & (period_q != 32'h0000_0000);
   assign wrap_hit  = count_q == period_q;
   assign match_hit = (count_q == compare_q) & (compare_q <= period_q);

   // counter, wraps to zero after reaching the period
   always_ff @(posedge clock) begin
      if (srst) begin
         count_q <= ltc_pkg::WORD_RESET;
         arm_q   <= 2'h0;
         mute_q  <= 2'h0;
      end else begin
         if (half_tick & cnt_pend_q) begin
            count_q <= cnt_stage_q;
         end else if (rise_tick & run) begin
            count_q <= wrap_hit ? 32'h0000_0000 : count_q + 32'h1;
         end
         if (rise_tick & run) begin
            arm_q[ltc_pkg::FLAG_WRAP]  <= wrap_hit & (mute_q == 2'h0);
            arm_q[ltc_pkg::FLAG_MATCH] <= match_hit & (mute_q == 2'h0);
         end
         if ((half_tick & cnt_pend_q)
             | (wr_ok & (wr_idx == ltc_pkg::IDX_CMP3))
             | wr_per) begin
            mute_q <= ltc_pkg::MUTE_TICKS;
         end else if (rise_tick & (mute_q != 2'h0)) begin
            mute_q <= mute_q - 2'h1;
         end
      end
   end

   // flags are set on the count after the hit
   assign set_v = (rise_tick & run) ? arm_q : 2'h0;
   assign clr_v[ltc_pkg::FLAG_WRAP]  = wrap_irq_ack;
   assign clr_v[ltc_pkg::FLAG_MATCH] = match_irq_ack;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
         logic [1:0] evt_cnt_q;
         logic       sw_clr;
         logic [1:0] evt_last;
         assign sw_clr = wr_ok & wr_byte[gi]
                         & ((wr_idx == ltc_pkg::IDX_FLAGS)
                            | (wr_idx == ltc_pkg::IDX_IRQ_CLR));
         assign evt_last = (period_q == 32'h0000_0000) ? 2'h2
                         : (period_q == 32'h0000_0001) ? 2'h1 : 2'h0;
         // set wins over a clear in the same cycle
         always_ff @(posedge clock) begin
            if (srst) begin
               flag_q[gi] <= 1'b0;
            end else begin
               flag_q[gi] <= set_v[gi]
                             | (flag_q[gi] & ~clr_v[gi] & ~sw_clr);
            end
         end
         always_ff @(posedge clock) begin
            if (srst) begin
               evt_cnt_q   <= 2'h0;
               event_q[gi] <= 1'b0;
            end else begin
               event_q[gi] <= set_v[gi] & (evt_cnt_q == 2'h0);
               if (set_v[gi]) begin
                  evt_cnt_q <= (evt_cnt_q >= evt_last) ? 2'h0
                                                       : evt_cnt_q + 2'h1;
               end
            end
         end
      end
   endgenerate

   // count readback into the register side
   always_ff @(posedge clock) begin
      if (srst) begin
         rb_req_q   <= 1'b0;
         rb_cnt_q   <= 4'h0;
         readback_q <= ltc_pkg::WORD_RESET;
      end else if (wr_rb) begin
         rb_req_q <= 1'b1;
         rb_cnt_q <= ltc_pkg::READBACK_CYCLES;
      end else if (rb_req_q) begin
         rb_cnt_q <= rb_cnt_q - 4'h1;
         if (rb_cnt_q == 4'h1) begin
            rb_req_q   <= 1'b0;
            readback_q <= count_q;
         end
      end
   end

   // interrupt requests, events and wake-up
   always_ff @(posedge clock) begin
      if (srst) begin
         irq                <= 1'b0;
         match_irq_req      <= 1'b0;
         wrap_irq_req       <= 1'b0;
         match_irq_priority <= 2'h0;
         wrap_irq_priority  <= 2'h0;
         match_event        <= 1'b0;
         wrap_event         <= 1'b0;
         wake_request       <= 1'b0;
      end else begin
         irq                <= |(flag_q & irq_en_q);
         match_irq_req      <= flag_q[ltc_pkg::FLAG_MATCH]
                               & (match_lvl_q != 2'h0);
         wrap_irq_req       <= flag_q[ltc_pkg::FLAG_WRAP]
                               & (wrap_lvl_q != 2'h0);
         match_irq_priority <= match_lvl_q;
         wrap_irq_priority  <= wrap_lvl_q;
         match_event        <= event_q[ltc_pkg::FLAG_MATCH];
         wrap_event         <= event_q[ltc_pkg::FLAG_WRAP];
         wake_request       <= |set_v;
      end
   end

   // read channel
   assign rd_mapped = is_mapped(araddr[7:2]);
   always_comb begin
      rd_word = ltc_pkg::WORD_RESET;
      unique case (araddr[7:2])
         ltc_pkg::IDX_CTRL:     rd_word[0] = enable_q;
         ltc_pkg::IDX_SYNC: begin
            rd_word[ltc_pkg::SYNC_BUSY_BIT] = busy;
            rd_word[ltc_pkg::SYNC_CNT_BIT]  = rb_req_q;
         end
         ltc_pkg::IDX_INTLVL:   rd_word[3:0] = {match_lvl_q, wrap_lvl_q};
         ltc_pkg::IDX_FLAGS,
         ltc_pkg::IDX_IRQ_STAT: rd_word[1:0] = flag_q;
         ltc_pkg::IDX_IRQ_EN:   rd_word[1:0] = irq_en_q;
         default: begin
            if (araddr[7:2] == ltc_pkg::IDX_IRQ_CLR) begin
               rd_word = ltc_pkg::WORD_RESET;
            end else if (araddr[7:4] == 4'h1) begin
               rd_word[7:0] = readback_q[8*(araddr[3:2]) +: 8];
            end else if (araddr[7:4] == 4'h2) begin
               rd_word[7:0] = period_q[8*(araddr[3:2]) +: 8];
            end else if (araddr[7:4] == 4'h3) begin
               rd_word[7:0] = compare_q[8*(araddr[3:2]) +: 8];
            end
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= ltc_pkg::WORD_RESET;
         rresp   <= ltc_pkg::RESP_OKAY;
      end else if (arvalid & arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= rd_word;
         rresp   <= rd_mapped ? ltc_pkg::RESP_OKAY : ltc_pkg::RESP_DECERR;
      end else if (rvalid & rready) begin
         rvalid <= 1'b0;
      end else if (~rvalid) begin
         arready <= 1'b1;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   sequence s_rb_quiet;
      !wr_rb [*8];
   endsequence

   sequence s_rb_wait;
      rb_req_q ##1 !rb_req_q;
   endsequence

   property p_wrap_zero;
      rise_tick && run && wrap_hit && !(half_tick && cnt_pend_q)
         |=> count_q == 32'h0000_0000;
   endproperty
   a_wrap_zero: assert property (p_wrap_zero)
      else $error("count did not wrap to zero");

   property p_match_next;
      rise_tick && run && arm_q[1] |=> flag_q[1];
   endproperty
   a_match_next: assert property (p_match_next)
      else $error("match flag not set on next count");

   property p_stopped;
      !run && !(half_tick && cnt_pend_q) |=> $stable(count_q);
   endproperty
   a_stopped: assert property (p_stopped)
      else $error("count moved while stopped");

   property p_readback;
      wr_rb ##1 s_rb_quiet |-> s_rb_wait;
   endproperty
   a_readback: assert property (p_readback)
      else $error("readback not done after eight cycles");

   property p_busy_set;
      wr_cnt && !busy && wr_idx == ltc_pkg::IDX_CNT3 |=> busy;
   endproperty
   a_busy_set: assert property (p_busy_set)
      else $error("busy flag not raised by count transfer");

   property p_cnt_ignored;
      wr_cnt && busy |=> $stable(cnt_stage_q);
   endproperty
   a_cnt_ignored: assert property (p_cnt_ignored)
      else $error("count write accepted while busy");

   property p_per_locked;
      wr_per && (enable_q || busy) |=> $stable(period_q);
   endproperty
   a_per_locked: assert property (p_per_locked)
      else $error("period changed while locked");

   property p_wrap_req;
      flag_q[0] && wrap_lvl_q != 2'h0 |=> wrap_irq_req;
   endproperty
   a_wrap_req: assert property (p_wrap_req)
      else $error("wrap request missing");

   property p_match_req;
      match_irq_req |-> $past(flag_q[1]) && $past(match_lvl_q) != 2'h0;
   endproperty
   a_match_req: assert property (p_match_req)
      else $error("match request without cause");

   property p_enable_half;
      half_tick && ctrl_pend_q |=> enable_live_q == $past(enable_q);
   endproperty
   a_enable_half: assert property (p_enable_half)
      else $error("enable not applied at half tick");
endmodule

// File: test/tb_long_period_time_counter.sv
module tb_long_period_time_counter;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clock, srst, xtal_in, sel_1hz, m_ack, w_ack;
   logic [7:0]  awaddr, araddr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, v, g;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, mprio, wprio, seen;
   logic        irq, mreq, wreq, mev, wev, wake;
   logic [34:0] e;
   logic [34:0] expq[$];
   int          fails, tests_run;

   ltc_long_time_counter #(.SLOW_XTAL(64)) u_dut (
      .clock(clock), .srst(srst), .xtal_in(xtal_in), .sel_1hz(sel_1hz),
      .match_irq_ack(m_ack), .wrap_irq_ack(w_ack),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .irq(irq), .match_irq_req(mreq), .match_irq_priority(mprio),
      .wrap_irq_req(wreq), .wrap_irq_priority(wprio),
      .match_event(mev), .wrap_event(wev), .wake_request(wake));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   initial begin
      xtal_in = 1'b0;
      forever begin
         repeat (4) @(posedge clock);
         xtal_in <= ~xtal_in;
      end
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction

   task automatic cmp(input logic [31:0] a, input logic [31:0] b,
                      input string m);
      tests_run++;
      if (a !== b) begin
         fails++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic wr(input logic [5:0] i, input logic [7:0] d);
      awaddr  <= {i, 2'h0};
      wdata   <= {24'h0, d};
      wstrb   <= 4'hF;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge clock);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
   endtask

   task automatic rd(input logic [5:0] i, input logic [7:0] x,
                     input logic c);
      logic [1:0] r;
      r = (i > ltc_pkg::IDX_IRQ_EN) ? ltc_pkg::RESP_DECERR
                                    : ltc_pkg::RESP_OKAY;
      expq.push_back({c, 24'h0, x, r});
      araddr  <= {i, 2'h0};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge clock);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      g = rdata;
   endtask

   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         rd(ltc_pkg::IDX_SYNC, 8'h00, 1'b0);
         n++;
      end while (g[0] !== 1'b0 && n < 200);
      cmp(32'(n < 200), 32'h1, "busy stuck");
   endtask

   task automatic wait_wrap;
      int n;
      n = 0;
      while (wev !== 1'b1 && n < 3000) begin
         @(posedge clock);
         n++;
      end
      cmp(32'(n < 3000), 32'h1, "no wrap event");
   endtask

   task automatic wcnt(input logic [31:0] x);
      for (int k = 0; k < 4; k++)
         wr(ltc_pkg::IDX_CNT0 + 6'(k), x[8*k +: 8]);
   endtask

   always @(posedge clock) begin
      if (srst === 1'b0) seen <= seen | {wake, mev};
      if (rvalid === 1'b1 && rready === 1'b1) begin
         e = expq.pop_front();
         if (e[34]) cmp(rdata, e[33:2], "read data");
         cmp({30'h0, rresp}, {30'h0, e[1:0]}, "read response");
      end
      if (bvalid === 1'b1 && bready === 1'b1)
         cmp({30'h0, bresp}, {30'h0, ltc_pkg::RESP_OKAY}, "write response");
   end

   initial begin
      repeat (40000) @(posedge clock);
      fails++;
      complete_run;
   end

   initial begin
      {srst, sel_1hz, m_ack, w_ack, seen} = 6'h20;
      {awaddr, araddr, wdata, wstrb} = 52'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      repeat (10) @(posedge clock);
      srst <= 1'b0;
      repeat (2) @(posedge clock);
      rd(ltc_pkg::IDX_CTRL, 8'h00, 1'b1);
      rd(ltc_pkg::IDX_SYNC, 8'h00, 1'b1);
      rd(ltc_pkg::IDX_FLAGS, 8'h00, 1'b1);
      rd(6'h13, 8'h00, 1'b1);
      wr(ltc_pkg::IDX_INTLVL, 8'h0F);
      rd(ltc_pkg::IDX_INTLVL, 8'h0F, 1'b1);
      repeat (2) @(posedge clock);
      cmp({28'h0, mprio, wprio}, 32'hF, "priority");
      $display("registers done");
      v = xs(32'hDB4A);
      wcnt(v);
      wait_idle();
      wr(ltc_pkg::IDX_CTRL, 8'h01);
      wait_idle();
      repeat (600) @(posedge clock);
      wr(ltc_pkg::IDX_SYNC, 8'h10);
      repeat (12) @(posedge clock);
      rd(ltc_pkg::IDX_SYNC, 8'h00, 1'b1);
      for (int k = 0; k < 4; k++)
         rd(ltc_pkg::IDX_CNT0 + 6'(k), v[8*k +: 8], 1'b1);
      wr(ltc_pkg::IDX_CTRL, 8'h00);
      wait_idle();
      $display("count done");
      wcnt(32'h0);
      wr(ltc_pkg::IDX_CNT0, 8'h55);
      wait_idle();
      wr(ltc_pkg::IDX_PER0, 8'h03);
      wr(ltc_pkg::IDX_CMP0, 8'h01);
      wr(ltc_pkg::IDX_INTLVL, 8'h05);
      wr(ltc_pkg::IDX_IRQ_EN, 8'h03);
      wr(ltc_pkg::IDX_CTRL, 8'h01);
      wait_idle();
      wr(ltc_pkg::IDX_PER0, 8'h09);
      rd(ltc_pkg::IDX_PER0, 8'h03, 1'b1);
      wait_wrap();
      repeat (2) @(posedge clock);
      cmp({30'h0, wreq, irq}, 32'h3, "wrap request");
      wr(ltc_pkg::IDX_IRQ_EN, 8'h00);
      repeat (2) @(posedge clock);
      cmp({31'h0, irq}, 32'h0, "irq masked");
      wr(ltc_pkg::IDX_IRQ_CLR, 8'h03);
      rd(ltc_pkg::IDX_IRQ_STAT, 8'h00, 1'b1);
      wait_wrap();
      repeat (2) @(posedge clock);
      cmp({31'h0, mreq}, 32'h1, "match request");
      rd(ltc_pkg::IDX_FLAGS, 8'h03, 1'b1);
      w_ack <= 1'b1;
      @(posedge clock);
      w_ack <= 1'b0;
      repeat (2) @(posedge clock);
      rd(ltc_pkg::IDX_FLAGS, 8'h02, 1'b1);
      m_ack <= 1'b1;
      @(posedge clock);
      m_ack <= 1'b0;
      repeat (2) @(posedge clock);
      rd(ltc_pkg::IDX_FLAGS, 8'h00, 1'b1);
      cmp({30'h0, seen}, 32'h3, "wake and match event");
      $display("interrupts done");
      complete_run;
   end
endmodule
